// file: include/ceenc_regs.svh
// Offsets, field positions, encodings and reset values of the compound error code encoder
`ifndef CEENC_REGS_SVH
`define CEENC_REGS_SVH
`define CEENC_ADR_CTRL 8'h00
`define CEENC_ADR_CODE 8'h04
`define CEENC_ADR_COUNT 8'h08
`define CEENC_CTRL_RESET 2'h1
`define CEENC_CTRL_EN_BIT 0
`define CEENC_CTRL_FILT_BIT 1
`define CEENC_CODE_VALID_BIT 16
`define CEENC_CODE_BANK_LSB 20
`define CEENC_F_BIT 12
`define CEENC_KIND_GENERIC 2'h2
`define CEENC_LVL_GENERIC 2'h3
`define CEENC_REQ_ERR 4'h0
`define CEENC_REQ_RD 4'h1
`define CEENC_REQ_WR 4'h2
`define CEENC_REQ_DRD 4'h3
`define CEENC_REQ_DWR 4'h4
`define CEENC_REQ_IRD 4'h5
`define CEENC_REQ_CASTOUT 4'h7
`define CEENC_REQ_SNOOP 4'h8
`define CEENC_ROLE_GENERIC 2'h3
`define CEENC_SPACE_RESERVED 2'h1
`define CEENC_SPACE_OTHER 2'h3
`define CEENC_MEM_GENERIC 3'h0
`define CEENC_MEM_LAST 3'h4
`define CEENC_CHAN_NONE 4'hf
`define CEENC_TLB_MARK 8'h01
`define CEENC_CACHE_MARK 4'h1
`define CEENC_EXT_MARK 4'h2
`define CEENC_GEN_MARK 2'h3
`endif

// file: include/ceenc_pkg.sv
// Types shared by the compound error code encoder
package ceenc_pkg;
    typedef enum logic [2:0] {
        CEENC_CL_GENCACHE = 3'h0,
        CEENC_CL_TLB = 3'h1,
        CEENC_CL_MEMCTL = 3'h2,
        CEENC_CL_CACHE = 3'h3,
        CEENC_CL_EXTMEM = 3'h4,
        CEENC_CL_BUS = 3'h5
    } ceenc_class_t;
endpackage

// file: rtl/ceenc_top.sv
// Compound error code encoder with a classic Wishbone register slave
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "ceenc_regs.svh"

// Operation
// R1: Transaction kind: instruction 00, data 01, generic 10
// R2: Unknown transaction kind reports generic 10
// R3: Kind and level only in TLB, cache, bus; the code puts kind in TLB and cache only, and level also in generic cache
// R4: Level encodes 0,1,2 and generic 11
// R5: Unknown level reports generic 11
// R6: Request field encodes nine four-bit request kinds
// R7: Unknown side gives generic read/write; unknown gives 0000
// R8: Castout and snoop only for cache errors
// R9: Role: originator, answering, witness, generic
// R10: Time-out bit set only when request timed out
// R11: Space: memory 00, I/O 10, other 11
// R12: Bus form also carries level and request
// R13: Memory transaction 000 to 100, rest reserved
// R14: Channel 0000-1110, 1111 when unspecified
// R15: Extended memory uses memory-controller encodings
// R16: Channel identified together with reporting bank
// R17: TLB and cache forms have fixed layouts
// R18: Bus and memory forms have fixed layouts
// R19: Bit 12 filter flag, ignored when uncorrected; the code never sets it in the generic cache form
// R20: Never emit reserved space or memory values
module ceenc_top
    import ceenc_pkg::*;
#(
    parameter logic [3:0] BANK_ID = 4'h0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Error attributes from the detecting unit
    input wire logic i_err_valid,
    input wire ceenc_class_t i_class,
    input wire logic i_kind_known,
    input wire logic [1:0] i_transaction_kind,
    input wire logic i_level_known,
    input wire logic [1:0] i_hierarchy_level,
    input wire logic i_req_known,
    input wire logic i_side_known,
    input wire logic [3:0] i_request_kind,
    input wire logic [1:0] i_participation_role,
    input wire logic i_timed_out,
    input wire logic [1:0] i_memory_or_io_space,
    input wire logic [2:0] i_memory_transaction_kind,
    input wire logic i_chan_valid,
    input wire logic [3:0] i_channel_index,
    input wire logic i_filter,
    input wire logic i_uncorrected,
    // Encoded code
    output logic [15:0] o_code,
    output logic o_code_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // Field functions

    function automatic logic [1:0] f_kind(input logic known, input logic [1:0] kind);
        // Code 11 has no meaning, so it also falls back to generic
        if (!known || kind == 2'h3) begin
            f_kind = `CEENC_KIND_GENERIC; // [R2]
        end else begin
            f_kind = kind; // [R1]
        end
    endfunction

    function automatic logic [1:0] f_level(input logic known, input logic [1:0] lvl);
        f_level = known ? lvl : `CEENC_LVL_GENERIC; // [R4] [R5]
    endfunction

    function automatic logic [3:0] f_req(input logic is_cache, input logic known, input logic side,
                                         input logic [3:0] r);
        logic [3:0] v;
        v = r;
        if (!known || r > `CEENC_REQ_SNOOP) begin
            v = `CEENC_REQ_ERR; // [R6] [R7]
        end else if (!side && (r == `CEENC_REQ_DRD || r == `CEENC_REQ_IRD)) begin
            v = `CEENC_REQ_RD; // [R7]
        end else if (!side && r == `CEENC_REQ_DWR) begin
            v = `CEENC_REQ_WR; // [R7]
        end
        if (!is_cache && (v == `CEENC_REQ_CASTOUT || v == `CEENC_REQ_SNOOP)) begin
            v = `CEENC_REQ_ERR; // [R8]
        end
        f_req = v;
    endfunction

    function automatic logic [6:0] f_mem(input logic [2:0] m, input logic cv, input logic [3:0] ch);
        logic [2:0] mk;
        mk = (m > `CEENC_MEM_LAST) ? `CEENC_MEM_GENERIC : m; // [R13] [R20]
        f_mem = {mk, cv ? ch : `CEENC_CHAN_NONE}; // [R14]
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Encoder

    logic [1:0] ctrl_reg;
    logic [1:0] ctrl_next;
    logic [15:0] code_reg;
    logic [15:0] code_next;
    logic code_valid_reg;
    logic code_valid_next;
    logic sticky_reg;
    logic sticky_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [31:0] wb_dat_reg;
    logic [31:0] wb_dat_next;
    logic wb_ack_reg;
    logic wb_ack_next;
    logic capture;
    logic bus_req;
    logic [1:0] kind_f;
    logic [1:0] lvl_f;
    logic [3:0] req_f;
    logic [1:0] space_f;
    logic [6:0] mem_f;
    logic filt_f;
    logic [15:0] enc;

    assign capture = i_err_valid && ctrl_reg[`CEENC_CTRL_EN_BIT];
    assign bus_req = i_wb_cyc && i_wb_stb && !wb_ack_reg;

    always_comb begin
        kind_f = f_kind(i_kind_known, i_transaction_kind);
        lvl_f = f_level(i_level_known, i_hierarchy_level);
        req_f = f_req(i_class == CEENC_CL_CACHE, i_req_known, i_side_known, i_request_kind);
        // Extended memory shares the memory-controller field encodings
        mem_f = f_mem(i_memory_transaction_kind, i_chan_valid, i_channel_index); // [R15]
        space_f = (i_memory_or_io_space == `CEENC_SPACE_RESERVED) ? `CEENC_SPACE_OTHER
                                                                 : i_memory_or_io_space; // [R11] [R20]
        // Filtering means nothing for uncorrected errors, so never flag those
        filt_f = i_filter && !i_uncorrected && ctrl_reg[`CEENC_CTRL_FILT_BIT]; // [R19]
        enc = 16'h0000;
        unique case (i_class)
            CEENC_CL_GENCACHE: begin
                enc[3:0] = {`CEENC_GEN_MARK, lvl_f};
            end
            CEENC_CL_TLB: begin
                enc[11:0] = {`CEENC_TLB_MARK, kind_f, lvl_f}; // [R3] [R17]
            end
            CEENC_CL_MEMCTL: begin
                enc[7:0] = {1'b1, mem_f}; // [R18]
            end
            CEENC_CL_CACHE: begin
                enc[11:0] = {`CEENC_CACHE_MARK, req_f, kind_f, lvl_f}; // [R3] [R17]
            end
            CEENC_CL_EXTMEM: begin
                enc[11:0] = {`CEENC_EXT_MARK, 1'b1, mem_f}; // [R15] [R18]
            end
            CEENC_CL_BUS: begin
                // Bus form keeps level and request next to role, time-out and space
                enc[11:0] = {1'b1, i_participation_role, i_timed_out, req_f, space_f, lvl_f}; // [R9] [R10] [R12] [R18]
            end
            default: begin
                enc = 16'h0000;
            end
        endcase
        if (i_class != CEENC_CL_GENCACHE) begin
            enc[`CEENC_F_BIT] = filt_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register next state

    always_comb begin
        ctrl_next = ctrl_reg;
        code_next = code_reg;
        code_valid_next = capture;
        sticky_next = sticky_reg;
        count_next = count_reg;
        wb_ack_next = bus_req;
        wb_dat_next = 32'h0000_0000;
        if (bus_req && i_wb_we) begin
            if (i_wb_adr == `CEENC_ADR_CTRL && i_wb_sel[0]) begin
                ctrl_next = i_wb_dat[1:0];
            end
            if (i_wb_adr == `CEENC_ADR_CODE && i_wb_sel[2] && i_wb_dat[`CEENC_CODE_VALID_BIT]) begin
                sticky_next = 1'b0;
            end
            if (i_wb_adr == `CEENC_ADR_COUNT && (|i_wb_sel[1:0])) begin
                count_next = 16'h0000;
            end
        end else if (bus_req) begin
            unique case (i_wb_adr)
                `CEENC_ADR_CTRL: wb_dat_next = {30'h0000_0000, ctrl_reg};
                // Bank number lets software tell apart channels that each controller counts from zero
                `CEENC_ADR_CODE: wb_dat_next = {8'h00, BANK_ID, 3'h0, sticky_reg, code_reg}; // [R16]
                `CEENC_ADR_COUNT: wb_dat_next = {16'h0000, count_reg};
                default: wb_dat_next = 32'h0000_0000;
            endcase
        end
        // A new code wins over a clear in the same cycle
        if (capture) begin
            code_next = enc;
            sticky_next = 1'b1;
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= `CEENC_CTRL_RESET;
            code_reg <= 16'h0000;
            code_valid_reg <= 1'b0;
            sticky_reg <= 1'b0;
            count_reg <= 16'h0000;
            wb_dat_reg <= 32'h0000_0000;
            wb_ack_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            code_reg <= code_next;
            code_valid_reg <= code_valid_next;
            sticky_reg <= sticky_next;
            count_reg <= count_next;
            wb_dat_reg <= wb_dat_next;
            wb_ack_reg <= wb_ack_next;
        end
    end

    assign o_code = code_reg;
    assign o_code_valid = code_valid_reg;
    assign o_wb_dat = wb_dat_reg;
    assign o_wb_ack = wb_ack_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_tt_generic;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_class == CEENC_CL_TLB && !i_kind_known |=> o_code[3:2] == 2'h2;
    endproperty
    a_tt_generic: assert property (p_tt_generic) else $error("unknown kind not generic"); // [R2]

    property p_lvl_generic;
        @(posedge i_clk) disable iff (i_rst)
        capture && (i_class == CEENC_CL_CACHE || i_class == CEENC_CL_BUS) && !i_level_known
            |=> o_code[1:0] == 2'h3;
    endproperty
    a_lvl_generic: assert property (p_lvl_generic) else $error("unknown level not generic"); // [R5]

    property p_req_unknown;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_class == CEENC_CL_CACHE && !i_req_known |=> o_code[7:4] == 4'h0;
    endproperty
    a_req_unknown: assert property (p_req_unknown) else $error("unknown request not generic"); // [R7]

    property p_side_unknown;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_class == CEENC_CL_CACHE && i_req_known && !i_side_known && i_request_kind == 4'h4
            |=> o_code[7:4] == 4'h2;
    endproperty
    a_side_unknown: assert property (p_side_unknown) else $error("data write not made generic"); // [R7]

    property p_castout_cache;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_class == CEENC_CL_BUS |=> o_code[7:4] != 4'h7 && o_code[7:4] != 4'h8;
    endproperty
    a_castout_cache: assert property (p_castout_cache) else $error("castout or snoop on bus"); // [R8]

    property p_bus_form;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_class == CEENC_CL_BUS |=> o_code[11] && o_code[3:2] != 2'h1
            && o_code[8] == $past(i_timed_out) && o_code[10:9] == $past(i_participation_role);
    endproperty
    a_bus_form: assert property (p_bus_form) else $error("bus form wrong"); // [R18]

    property p_mem_form;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_class == CEENC_CL_EXTMEM && !i_chan_valid
            |=> o_code[11:7] == 5'h05 && o_code[6:4] <= 3'h4 && o_code[3:0] == 4'hf;
    endproperty
    a_mem_form: assert property (p_mem_form) else $error("memory form wrong"); // [R14]

    property p_tlb_form;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_class == CEENC_CL_TLB |=> o_code[15:13] == 3'h0 && o_code[11:4] == 8'h01;
    endproperty
    a_tlb_form: assert property (p_tlb_form) else $error("tlb form wrong"); // [R17]

    property p_filter_uc;
        @(posedge i_clk) disable iff (i_rst)
        capture && i_uncorrected |=> !o_code[12];
    endproperty
    a_filter_uc: assert property (p_filter_uc) else $error("filter bit on uncorrected"); // [R19]

    property p_valid_pulse;
        @(posedge i_clk) disable iff (i_rst)
        capture ##1 !capture |-> o_code_valid ##1 !o_code_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid pulse wrong");

endmodule

// file: tb/tb_top.sv
// Self-checking bench for the compound error code encoder
`timescale 1ns/100ps
`include "ceenc_regs.svh"
module tb_top
    import ceenc_pkg::*;
;
    typedef struct packed {
        ceenc_class_t cls;
        logic kk;
        logic [1:0] tk;
        logic lk;
        logic [1:0] lv;
        logic rk;
        logic sk;
        logic [3:0] rq;
        logic [1:0] role;
        logic to;
        logic [1:0] sp;
        logic [2:0] mm;
        logic cv;
        logic [3:0] ch;
        logic fl;
        logic uc;
    } ceenc_attr_t;
    // Arbitrary bank number, chosen non-zero so a stuck field shows
    localparam logic [3:0] BANK = 4'h5;
    logic clk, rst, cyc, stb, we, ack, ev, cvld, en;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, od, rd;
    logic [15:0] code, last;
    ceenc_attr_t a;
    int err_count, cmp_count, ncap;

    ceenc_top #(.BANK_ID(BANK)) i_dut (
        .i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(od), .o_wb_ack(ack),
        .i_err_valid(ev), .i_class(a.cls), .i_kind_known(a.kk), .i_transaction_kind(a.tk),
        .i_level_known(a.lk), .i_hierarchy_level(a.lv), .i_req_known(a.rk),
        .i_side_known(a.sk), .i_request_kind(a.rq), .i_participation_role(a.role),
        .i_timed_out(a.to), .i_memory_or_io_space(a.sp), .i_memory_transaction_kind(a.mm),
        .i_chan_valid(a.cv), .i_channel_index(a.ch), .i_filter(a.fl), .i_uncorrected(a.uc),
        .o_code(code), .o_code_valid(cvld)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Holds the request until ack is seen at an edge; the bench fails if no ack comes within 20 edges
    task automatic wb(input logic w, input logic [7:0] ad, input logic [3:0] s, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= ad;
        sel <= s;
        wd <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'h1) break;
        end
        if (n == 20) begin
            err_count++;
            give_verdict();
        end
        rd = od;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [31:0] e, input string n);
        wb(1'h0, ad, 4'hf, 32'h0000_0000);
        chk(n, rd, e);
    endtask

    function automatic ceenc_attr_t base(input ceenc_class_t c);
        return '{c, 1'h1, 2'h0, 1'h1, 2'h0, 1'h1, 1'h1, 4'h0, 2'h0, 1'h0, 2'h0, 3'h0, 1'h1, 4'h0, 1'h0, 1'h0};
    endfunction

    // At most one capture per call, none with enable off; the event is always launched on a rising edge
    task automatic fire(input ceenc_attr_t t, input logic [15:0] e);
        @(posedge clk);
        a <= t;
        ev <= 1'h1;
        @(posedge clk);
        ev <= 1'h0;
        #1;
        if (en) begin
            last = e;
            ncap++;
        end
        chk("code", {16'h0000, code}, {16'h0000, last});
        chk("code_valid", {31'h0, cvld}, {31'h0, en});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        chk("code", {16'h0000, code}, 32'h0000_0000);
        rchk(8'h00, 32'h0000_0001, "ctrl");
        rchk(8'h04, {8'h00, BANK, 20'h0_0000}, "code_reg");
        rchk(8'h08, 32'h0000_0000, "count");
        rchk(8'h0c, 32'h0000_0000, "unmapped");
    endtask

    task automatic s_tlb();
        ceenc_attr_t t;
        for (int i = 0; i < 16; i++) begin
            t = base(CEENC_CL_TLB);
            t.tk = 2'(i >> 2);
            t.lv = 2'(i);
            fire(t, {12'h001, (t.tk == 2'h3) ? 2'h2 : t.tk, t.lv});
            t.cls = CEENC_CL_GENCACHE;
            fire(t, {14'h0003, t.lv});
        end
        t = base(CEENC_CL_TLB);
        t.kk = 1'h0;
        t.lk = 1'h0;
        t.tk = 2'h1;
        t.lv = 2'h1;
        fire(t, 16'h001b);
    endtask

    task automatic s_req();
        ceenc_attr_t t;
        for (int i = 0; i < 9; i++) begin
            t = base(CEENC_CL_CACHE);
            t.rq = 4'(i);
            t.tk = 2'h1;
            t.lv = 2'h2;
            fire(t, {8'h01, t.rq, 4'h6});
            t.cls = CEENC_CL_BUS;
            fire(t, {8'h08, (i > 6) ? 4'h0 : t.rq, 4'h2});
        end
        t = base(CEENC_CL_CACHE);
        t.sk = 1'h0;
        t.rq = 4'h3;
        fire(t, 16'h0110);
        t.rq = 4'h4;
        fire(t, 16'h0120);
        t.rk = 1'h0;
        fire(t, 16'h0100);
        for (int i = 0; i < 16; i++) begin
            t = base(CEENC_CL_BUS);
            t.role = 2'(i >> 2);
            t.sp = 2'(i);
            t.to = t.sp[0];
            t.lv = t.role;
            t.rq = 4'h5;
            fire(t, {4'h0, 1'h1, t.role, t.to, 4'h5, (t.sp == 2'h1) ? 2'h3 : t.sp, t.lv});
        end
    endtask

    task automatic s_mem();
        ceenc_attr_t t;
        for (int i = 0; i < 256; i++) begin
            t = base(i[7] ? CEENC_CL_EXTMEM : CEENC_CL_MEMCTL);
            t.mm = 3'(i >> 4);
            t.ch = 4'(i);
            t.cv = (t.ch != 4'hf);
            if (!t.cv) t.ch = 4'h5;
            fire(t, {4'h0, i[7] ? 4'h2 : 4'h0, 1'h1, (t.mm > 3'h4) ? 3'h0 : t.mm, t.cv ? t.ch : 4'hf});
        end
    endtask

    task automatic s_regs();
        ceenc_attr_t t;
        rchk(8'h04, {8'h00, BANK, 4'h1, last}, "code_reg");
        wb(1'h1, 8'h04, 4'h4, 32'h0001_0000);
        rchk(8'h04, {8'h00, BANK, 4'h0, last}, "code_reg");
        rchk(8'h08, {16'h0000, ncap[15:0]}, "count");
        wb(1'h1, 8'h08, 4'h3, 32'h0000_0000);
        ncap = 0;
        rchk(8'h08, 32'h0000_0000, "count");
        wb(1'h1, 8'h00, 4'h1, 32'h0000_0003);
        t = base(CEENC_CL_CACHE);
        t.fl = 1'h1;
        fire(t, 16'h1100);
        t.uc = 1'h1;
        fire(t, 16'h0100);
        // Enable off: the event must leave no trace
        wb(1'h1, 8'h00, 4'h1, 32'h0000_0000);
        en = 1'h0;
        t.uc = 1'h0;
        fire(t, 16'h1100);
        rchk(8'h08, 32'h0000_0002, "count");
        wb(1'h1, 8'h0c, 4'hf, 32'hffff_ffff);
        wb(1'h1, 8'h00, 4'he, 32'h0000_0001);
        rchk(8'h00, 32'h0000_0000, "ctrl");
        wb(1'h1, 8'h00, 4'h1, 32'h0000_0001);
        en = 1'h1;
        fire(t, 16'h0100);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    initial begin
        rst = 1'h1;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 8'h00;
        sel = 4'h0;
        wd = 32'h0000_0000;
        ev = 1'h0;
        a = '0;
        en = 1'h1;
        last = 16'h0000;
        err_count = 0;
        cmp_count = 0;
        ncap = 0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        s_reset();
        s_tlb();
        s_req();
        s_mem();
        s_regs();
        give_verdict();
    end
endmodule
